/* hw/adc_pacing_and_result_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Start rate equals clock over primary divisor
// - Scan mode: expiry starts scan, else one
// - Second divisor spaces conversions, scan mode only
// - Scan channel zero now, rest at step
// - Eight 4-bit gain slots, used when advanced
// - Gain code selects per-pin input range
// - 12-bit level sets near-full entry count
// - Divisor zero: single 32-bit entries, 4095
// - Otherwise 64-bit entries, two results, 8190
// - Count register shows entries in low bits
// - Paired modes: two word reads per entry
// - Result word holds count, tags, pins, flags
// - Empty read returns word with invalid set
// - Running flag set while sequencer is active
// - Pin bits capture pins at sample time
// - Divisor zero selects software start mode
// - Scan needs enable and nonzero last channel
// - Thermal and aux flags mark result source
// - Differential flag follows sampling mode
// - Near-full latches at level, clear input clears below level
module adc_pacing_and_result_fifo
  import adc_pacing_pkg::*;
#(
  parameter int STAGE_DEPTH = 4,
  parameter int STORE_AW = 13
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic run_enable,
  input wire logic sw_start,
  input wire logic ext_start_pin,
  input wire logic [3:0] sampled_pin_states,
  input wire logic scan_enable,
  input wire logic [CHAN_W-1:0] last_scan_channel,
  input wire logic advanced_sequence,
  input wire logic [GAIN_W-1:0] amplification_code,
  input wire logic differential_mode,
  input wire logic aux_source,
  input wire logic thermal_source,
  output logic conv_start,
  output logic [CHAN_W-1:0] conv_channel,
  output logic [GAIN_W-1:0] conv_gain,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [15:0] result_count,
  output logic near_full_status,
  input wire logic near_full_clear
);
  // ===================================================
  // Registers
  logic [31:0] start_rate_divisor;
  logic [31:0] scan_step_divisor;
  logic [31:0] sequencer_gain_table;
  logic [COUNT_W-1:0] near_full_threshold;
  logic [COUNT_W-1:0] fifo_fill_count;
  logic wr_hit_start;
  logic rd_port;
  logic paired_mode;

  assign wr_hit_start = reg_write && (reg_addr == OFS_START_RATE_DIVISOR);
  assign rd_port = reg_read && (reg_addr == OFS_FIFO_RESULT_PORT);
  assign paired_mode = (start_rate_divisor != 32'h0000_0000);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_rate_divisor <= RST_DIVISOR;
      scan_step_divisor <= RST_DIVISOR;
      sequencer_gain_table <= RST_GAIN_TABLE;
      near_full_threshold <= RST_NEAR_FULL;
    end else if (reg_write) begin
      unique case (reg_addr)
        OFS_START_RATE_DIVISOR: start_rate_divisor <= reg_wdata;
        OFS_SCAN_STEP_DIVISOR: scan_step_divisor <= reg_wdata;
        // Reserved top bit of each slot is kept clear
        OFS_SEQUENCER_GAIN_TABLE: sequencer_gain_table <= reg_wdata & GAIN_TABLE_MASK;
        OFS_FIFO_NEAR_FULL_LEVEL: near_full_threshold <= reg_wdata[COUNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ===================================================
  // Pin synchronisers
  logic [1:0] ext_sync;
  logic ext_prev;
  logic [3:0] pins_meta;
  logic [3:0] pins_sync;
  logic ext_rise;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_sync <= 2'h0;
      ext_prev <= 1'b0;
      pins_meta <= 4'h0;
      pins_sync <= 4'h0;
    end else begin
      ext_sync <= {ext_sync[0], ext_start_pin};
      ext_prev <= ext_sync[1];
      pins_meta <= sampled_pin_states;
      pins_sync <= pins_meta;
    end
  end
  assign ext_rise = ext_sync[1] && !ext_prev;

  // ===================================================
  // Primary pacing divisor
  logic [31:0] rate_cnt;
  logic timed_run;
  logic rate_tick;
  logic start_evt;

  assign timed_run = run_enable && paired_mode;
  assign rate_tick = timed_run && (rate_cnt == 32'h0000_0000);
  // A software start only counts when the primary divisor is zero
  assign start_evt = rate_tick || ext_rise || (sw_start && !paired_mode);

  always_ff @(posedge ref_clk) begin
    if (wr_hit_start && !sys_rst) begin
      // A rewrite restarts the interval from the new value, not the old one
      rate_cnt <= reg_wdata - 32'h0000_0001;
    end else if (sys_rst || !timed_run) begin
      rate_cnt <= start_rate_divisor - 32'h0000_0001;
    end else if (rate_cnt == 32'h0000_0000) begin
      rate_cnt <= start_rate_divisor - 32'h0000_0001;
    end else begin
      rate_cnt <= rate_cnt - 32'h0000_0001;
    end
  end

  // ===================================================
  // Scan sequencer
  scan_state_t scan_state;
  logic [31:0] step_cnt;
  logic [31:0] step_reload;
  logic [CHAN_W-1:0] cur_chan;
  logic scan_mode;
  logic step_tick;
  logic launch;
  logic [CHAN_W-1:0] launch_chan;

  assign scan_mode = scan_enable && (last_scan_channel != '0);
  // A zero step divisor behaves as one clock per channel
  assign step_reload = (scan_step_divisor == 32'h0000_0000) ? 32'h0000_0000
                       : scan_step_divisor - 32'h0000_0001;
  assign step_tick = (scan_state == SCAN_RUN) && (step_cnt == 32'h0000_0000);

  always_comb begin
    launch = 1'b0;
    launch_chan = last_scan_channel;
    if (scan_state == SCAN_IDLE && start_evt) begin
      launch = 1'b1;
      launch_chan = scan_mode ? '0 : last_scan_channel;
    end else if (step_tick) begin
      launch = 1'b1;
      launch_chan = cur_chan + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_state <= SCAN_IDLE;
      cur_chan <= '0;
      step_cnt <= 32'h0000_0000;
    end else begin
      unique case (scan_state)
        SCAN_IDLE: begin
          if (start_evt && scan_mode) begin
            scan_state <= SCAN_RUN;
            cur_chan <= '0;
            step_cnt <= step_reload;
          end
        end
        SCAN_RUN: begin
          // Start events during a scan are dropped, not queued
          if (step_tick) begin
            cur_chan <= cur_chan + 1'b1;
            step_cnt <= step_reload;
            if (cur_chan + 1'b1 == last_scan_channel) begin
              scan_state <= SCAN_IDLE;
            end
          end else begin
            step_cnt <= step_cnt - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // ===================================================
  // Converter command and sample tags
  logic [GAIN_W-1:0] slot_gain;
  logic sequencer_active;
  logic [15:0] tag_bits;

  assign slot_gain = sequencer_gain_table[SLOT_W*launch_chan +: GAIN_W];
  assign sequencer_active = timed_run || run_enable || (scan_state == SCAN_RUN);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
      conv_channel <= '0;
      conv_gain <= '0;
    end else begin
      conv_start <= launch;
      if (launch) begin
        conv_channel <= launch_chan;
        // Gain code selects the input range inside the converter
        conv_gain <= advanced_sequence ? slot_gain : amplification_code;
      end
    end
  end

  // Tags are caught at the sampling moment; one conversion in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tag_bits <= 16'h0000;
    end else if (conv_start) begin
      tag_bits <= {1'b0, sequencer_active, pins_sync, thermal_source, aux_source,
                   1'b0, conv_channel, differential_mode, conv_gain};
    end
  end

  // ===================================================
  // Staging buffer and word store
  logic stage_valid;
  logic stage_take;
  logic [31:0] stage_data;
  logic [31:0] store [2**STORE_AW];
  logic [STORE_AW-1:0] wr_ptr;
  logic [STORE_AW-1:0] rd_ptr;
  logic [STORE_AW-1:0] words;
  logic wr_phase;
  logic rd_phase;
  logic entry_in;
  logic entry_out;
  logic pop;

  result_stage_fifo #(
    .WIDTH(32),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data({tag_bits, result_count}),
    .out_valid(stage_valid),
    .out_ready(stage_take),
    .out_data(stage_data)
  );

  assign words = wr_ptr - rd_ptr;
  // A full store stalls the stage, which in turn refuses the converter
  assign stage_take = words < (paired_mode ? PAIRED_CAP_WORDS[STORE_AW-1:0]
                                           : SINGLE_CAP_WORDS[STORE_AW-1:0]);
  assign pop = rd_port && (fifo_fill_count != '0);
  assign entry_in = stage_valid && stage_take && (!paired_mode || wr_phase);
  assign entry_out = pop && (!paired_mode || rd_phase);

  always_ff @(posedge ref_clk) begin
    if (stage_valid && stage_take) begin
      store[wr_ptr] <= stage_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      wr_phase <= 1'b0;
      rd_phase <= 1'b0;
      fifo_fill_count <= '0;
    end else begin
      if (stage_valid && stage_take) begin
        wr_ptr <= wr_ptr + 1'b1;
        wr_phase <= paired_mode && !wr_phase;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        rd_phase <= paired_mode && !rd_phase;
      end
      if (entry_in && !entry_out) begin
        fifo_fill_count <= fifo_fill_count + 1'b1;
      end else if (entry_out && !entry_in) begin
        fifo_fill_count <= fifo_fill_count - 1'b1;
      end
    end
  end

  // ===================================================
  // Near-full latch: a count at or above the level beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      near_full_status <= 1'b0;
    end else if (fifo_fill_count >= near_full_threshold) begin
      near_full_status <= 1'b1;
    end else if (near_full_clear) begin
      near_full_status <= 1'b0;
    end
  end

  // ===================================================
  // Read answers, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        unique case (reg_addr)
          OFS_START_RATE_DIVISOR: reg_rdata <= start_rate_divisor;
          OFS_SCAN_STEP_DIVISOR: reg_rdata <= scan_step_divisor;
          OFS_SEQUENCER_GAIN_TABLE: reg_rdata <= sequencer_gain_table;
          OFS_FIFO_NEAR_FULL_LEVEL: reg_rdata <= {20'h00000, near_full_threshold};
          OFS_FIFO_FILL_COUNT: reg_rdata <= {20'h00000, fifo_fill_count};
          OFS_FIFO_RESULT_PORT: reg_rdata <= pop ? store[rd_ptr] : INVALID_WORD;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // adc_pacing_and_result_fifo
`default_nettype wire

/* include/adc_pacing_pkg.sv */
`default_nettype none
package adc_pacing_pkg;
  // ===================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_START_RATE_DIVISOR = 8'h10;
  localparam logic [7:0] OFS_SCAN_STEP_DIVISOR = 8'h14;
  localparam logic [7:0] OFS_SEQUENCER_GAIN_TABLE = 8'h18;
  localparam logic [7:0] OFS_FIFO_NEAR_FULL_LEVEL = 8'h20;
  localparam logic [7:0] OFS_FIFO_FILL_COUNT = 8'h28;
  localparam logic [7:0] OFS_FIFO_RESULT_PORT = 8'h30;
  // ===================================================
  // Reset values and write masks
  localparam logic [31:0] RST_DIVISOR = 32'h0000_0000;
  localparam logic [31:0] RST_GAIN_TABLE = 32'h0000_0000;
  localparam logic [11:0] RST_NEAR_FULL = 12'h000;
  localparam logic [31:0] GAIN_TABLE_MASK = 32'h7777_7777;
  // ===================================================
  // Result word layout
  localparam int POS_COUNT = 0;
  localparam int POS_GAIN = 16;
  localparam int POS_DIFF = 19;
  localparam int POS_CHANNEL = 20;
  localparam int POS_AUX = 24;
  localparam int POS_THERMAL = 25;
  localparam int POS_PINS = 26;
  localparam int POS_RUNNING = 30;
  localparam int POS_INVALID = 31;
  localparam logic [31:0] INVALID_WORD = 32'h8000_0000;
  // ===================================================
  // Capacities and field sizes
  localparam int COUNT_W = 12;
  localparam logic [12:0] SINGLE_CAP_WORDS = 13'h0fff;
  localparam logic [12:0] PAIRED_CAP_WORDS = 13'h1ffe;
  localparam int SLOT_W = 4;
  localparam int GAIN_W = 3;
  localparam int CHAN_W = 3;
  // ===================================================
  // Scan sequencer states
  typedef enum logic [0:0] {
    SCAN_IDLE = 1'b0,
    SCAN_RUN = 1'b1
  } scan_state_t;
endpackage
`default_nettype wire

/* hw/result_stage_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module result_stage_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Sized to the level counter so the depth itself is never cut to the pointer width
  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] slots [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign in_ready = (level != FULL_LEVEL);
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = slots[rd_idx];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      slots[wr_idx] <= in_data;
    end
  end

  // Pointers wrap explicitly so any depth works, not only powers of two
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // result_stage_fifo
`default_nettype wire

/* tb/conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// Converter stand-in: answers each start after a short or long delay
module conv_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic result_ready,
  output logic result_valid,
  output logic [15:0] result_count
);
  logic [3:0] wait_n;
  logic [2:0] ch_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_n <= 4'h0;
    end else if (conv_start) begin
      wait_n <= slow ? 4'hc : 4'h2;
      ch_q <= conv_channel;
    end else if (wait_n != 4'h0) begin
      wait_n <= wait_n - 4'h1;
    end
  end
  // Count is inverted once taken, so a stale value never matches by luck
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
      result_count <= 16'h0000;
    end else if (wait_n == 4'h1) begin
      result_valid <= 1'b1;
      result_count <= {ch_q, 13'h0a5c};
    end else if (result_valid && result_ready) begin
      result_valid <= 1'b0;
      result_count <= ~result_count;
    end
  end
endmodule // conv_model
`default_nettype wire

/* tb/adc_pacing_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_pacing_chk
  import adc_pacing_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic scan_enable,
  input wire logic [CHAN_W-1:0] last_scan_channel,
  input wire logic advanced_sequence,
  input wire logic [GAIN_W-1:0] amplification_code,
  input wire logic conv_start,
  input wire logic [CHAN_W-1:0] conv_channel,
  input wire logic [GAIN_W-1:0] conv_gain,
  input wire logic near_full_status,
  input wire logic near_full_clear
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ==================================================
  // Register port
  rvalid_follow_a: assert property (reg_read |=> reg_rvalid)
    else $error("read not answered after one cycle");
  rvalid_only_a: assert property (!reg_read |=> !reg_rvalid)
    else $error("rvalid without a read");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  gain_mask_a: assert property (reg_rvalid && $past(reg_addr) == OFS_SEQUENCER_GAIN_TABLE
    |-> (reg_rdata & ~GAIN_TABLE_MASK) == 32'h0) else $error("gain slot top bit set");
  rsv_bit_a: assert property (reg_rvalid && $past(reg_addr) == OFS_FIFO_RESULT_PORT
    && !reg_rdata[POS_INVALID] |-> !reg_rdata[23]) else $error("result reserved bit set");
  unmapped_zero_a: assert property (reg_rvalid && $past(reg_addr) == 8'h04
    |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
  nf_sticky_a: assert property (near_full_status && !near_full_clear |=> near_full_status)
    else $error("near full dropped without clear");
  // ==================================================
  // Converter side
  chan_cause_a: assert property ($changed(conv_channel) |-> conv_start)
    else $error("channel changed without start");
  scan_bound_a: assert property (conv_start && scan_enable && last_scan_channel != 3'h0
    |-> conv_channel <= last_scan_channel) else $error("scan channel past last");
  single_chan_a: assert property (conv_start && !scan_enable
    |-> conv_channel == last_scan_channel) else $error("single channel wrong");
  basic_gain_a: assert property (conv_start && !advanced_sequence
    |-> conv_gain == amplification_code) else $error("basic gain wrong");
endmodule // adc_pacing_chk
bind adc_pacing_and_result_fifo adc_pacing_chk u_chk (.ref_clk, .sys_rst, .reg_addr, .reg_read,
  .reg_rdata, .reg_rvalid, .scan_enable, .last_scan_channel, .advanced_sequence,
  .amplification_code, .conv_start, .conv_channel, .conv_gain, .near_full_status,
  .near_full_clear);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_pacing_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid, conv_start, result_valid, result_ready, near_full_status;
  logic run_enable = 1'b0;
  logic sw_start = 1'b0;
  logic ext_start_pin = 1'b0;
  logic [3:0] sampled_pin_states = 4'ha;
  logic scan_enable = 1'b0;
  logic [2:0] last_scan_channel = 3'h0;
  logic advanced_sequence = 1'b0;
  logic [2:0] amplification_code = 3'h2;
  logic differential_mode = 1'b1;
  logic aux_source = 1'b0;
  logic thermal_source = 1'b1;
  logic [2:0] conv_channel, conv_gain;
  logic [15:0] result_count;
  logic near_full_clear = 1'b0;
  logic slow = 1'b0;
  logic [31:0] d;
  int g;
  int fails = 0;
  int n_tests = 0;
  adc_pacing_and_result_fifo #(.STAGE_DEPTH(4), .STORE_AW(13)) DUT (.ref_clk, .sys_rst,
    .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .run_enable,
    .sw_start, .ext_start_pin, .sampled_pin_states, .scan_enable, .last_scan_channel,
    .advanced_sequence, .amplification_code, .differential_mode, .aux_source,
    .thermal_source, .conv_start, .conv_channel, .conv_gain, .result_valid, .result_ready,
    .result_count, .near_full_status, .near_full_clear);
  conv_model u_conv (.ref_clk, .sys_rst, .slow, .conv_start, .conv_channel, .result_ready,
    .result_valid, .result_count);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ==================================================
  // Helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
    chk("rvalid", reg_rvalid, 1'b1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    rd(a, v);
    chk(name, v, exp);
  endtask
  // Polls the fill count; a bounded poll keeps a lost result from hanging the run
  task automatic wait_count(input logic [11:0] n);
    int i;
    logic [31:0] v;
    for (i = 0; i < 60; i++) begin
      rd(OFS_FIFO_FILL_COUNT, v);
      if (v[11:0] === n) break;
    end
    chk("count", {20'h0, v[11:0]}, {20'h0, n});
    if (i == 60) end_of_test();
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 1000) begin
        fails++;
        $display("BAD conv_start expected 1 seen 0");
        end_of_test();
      end
    end while (conv_start !== 1'b1);
  endtask
  task automatic sw_pulse();
    @(posedge ref_clk);
    sw_start <= 1'b1;
    @(posedge ref_clk);
    sw_start <= 1'b0;
  endtask
  function automatic logic [31:0] word(input logic run, input logic [2:0] ch,
    input logic [2:0] gn);
    return {1'b0, run, sampled_pin_states, thermal_source, aux_source, 1'b0, ch,
      differential_mode, gn, ch, 13'h0a5c};
  endfunction
  // ==================================================
  // Sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk(OFS_START_RATE_DIVISOR, RST_DIVISOR, "rate");
    rdchk(OFS_SEQUENCER_GAIN_TABLE, RST_GAIN_TABLE, "gain");
    rdchk(OFS_FIFO_FILL_COUNT, 32'h0, "count");
    rd(OFS_FIFO_RESULT_PORT, d);
    chk("empty", d[POS_INVALID], 1'b1);
    rdchk(8'h04, 32'h0, "unmapped");
    chk("nf_reset", near_full_status, 1'b1);
    chk("ready", result_ready, 1'b1);
    $display("test defaults done");
    wr(OFS_SEQUENCER_GAIN_TABLE, 32'hffff_ffff);
    rdchk(OFS_SEQUENCER_GAIN_TABLE, GAIN_TABLE_MASK, "gain_mask");
    wr(OFS_SEQUENCER_GAIN_TABLE, 32'h0000_4321); // Codes avoid six
    wr(OFS_FIFO_NEAR_FULL_LEVEL, 32'h0000_0fff);
    rd(OFS_FIFO_NEAR_FULL_LEVEL, d);
    chk("level", d[11:0], 12'hfff);
    wr(OFS_FIFO_FILL_COUNT, 32'h0000_0055);
    rdchk(OFS_FIFO_FILL_COUNT, 32'h0, "count_ro");
    wr(OFS_START_RATE_DIVISOR, 32'h8765_4321);
    rdchk(OFS_START_RATE_DIVISOR, 32'h8765_4321, "rate_rw");
    wr(OFS_SCAN_STEP_DIVISOR, 32'h8000_0005);
    rdchk(OFS_SCAN_STEP_DIVISOR, 32'h8000_0005, "step_rw");
    wr(OFS_START_RATE_DIVISOR, 32'h0);
    $display("test registers done");
    wr(OFS_FIFO_NEAR_FULL_LEVEL, 32'h0000_0002);
    @(posedge ref_clk);
    near_full_clear <= 1'b1;
    last_scan_channel <= 3'h3;
    @(posedge ref_clk);
    near_full_clear <= 1'b0;
    #1;
    chk("nf_clear", near_full_status, 1'b0);
    sw_pulse();
    wait_count(12'h001);
    @(posedge ref_clk);
    last_scan_channel <= 3'h5;
    sw_pulse();
    wait_count(12'h002);
    repeat (2) @(posedge ref_clk);
    chk("nf_set", near_full_status, 1'b1);
    rdchk(OFS_FIFO_RESULT_PORT, word(1'b0, 3'h3, 3'h2), "word");
    wait_count(12'h001);
    rdchk(OFS_FIFO_RESULT_PORT, word(1'b0, 3'h5, 3'h2), "word");
    wait_count(12'h000);
    @(posedge ref_clk);
    run_enable <= 1'b1;
    ext_start_pin <= 1'b1;
    wait_start(g);
    @(posedge ref_clk);
    ext_start_pin <= 1'b0;
    run_enable <= 1'b0;
    wait_count(12'h001);
    rdchk(OFS_FIFO_RESULT_PORT, word(1'b1, 3'h5, 3'h2), "ext_word");
    wait_count(12'h000);
    $display("test software start done");
    @(posedge ref_clk);
    sampled_pin_states <= 4'h5;
    thermal_source <= 1'b0;
    aux_source <= 1'b1;
    differential_mode <= 1'b0;
    last_scan_channel <= 3'h1;
    amplification_code <= 3'h7;
    slow <= 1'b1;
    wr(OFS_START_RATE_DIVISOR, 32'h0000_0028);
    @(posedge ref_clk);
    run_enable <= 1'b1;
    wait_start(g);
    wait_start(g);
    chk("gap", g, 32'd40);
    wait_start(g);
    chk("gap", g, 32'd40);
    wait_start(g);
    @(posedge ref_clk);
    run_enable <= 1'b0;
    wait_count(12'h002);
    // Word reads stand in for the wide transfer a host would prefer here
    for (int i = 0; i < 2; i++) begin
      rdchk(OFS_FIFO_RESULT_PORT, word(1'b1, 3'h1, 3'h7), "pword");
      rdchk(OFS_FIFO_RESULT_PORT, word(1'b1, 3'h1, 3'h7), "pword");
      wait_count(i == 0 ? 12'h001 : 12'h000);
    end
    $display("test timed pairs done");
    @(posedge ref_clk);
    scan_enable <= 1'b1;
    last_scan_channel <= 3'h3;
    advanced_sequence <= 1'b1;
    slow <= 1'b0;
    wr(OFS_SCAN_STEP_DIVISOR, 32'h0000_0005);
    wr(OFS_START_RATE_DIVISOR, 32'h0000_00c8);
    @(posedge ref_clk);
    run_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_start(g);
      chk("scan_ch", conv_channel, i);
      chk("scan_gain", conv_gain, i + 1);
      if (i > 0) chk("scan_gap", g, 32'd5);
    end
    @(posedge ref_clk);
    run_enable <= 1'b0;
    wait_count(12'h002);
    for (int i = 0; i < 4; i++) begin
      rdchk(OFS_FIFO_RESULT_PORT, word(1'b1, i, i + 1), "sword");
    end
    $display("test scan done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
